// ==== common/asc_pkg.sv ====
// Package: constants, types and register map of the ADC sleep and test-pattern control
package asc_pkg;
  // Clock and wake-up timing
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned T_SHUTDOWN_NS    = 2500000;
  localparam int unsigned T_STANDBY_NS     = 100000;
  localparam int unsigned T_DEEP_NS        = 20000;
  localparam int unsigned T_LIGHT_NS       = 2000;
  // Least times: round up to whole cycles
  localparam int unsigned CYC_SHUTDOWN     = (T_SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_STANDBY      = (T_STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_DEEP         = (T_DEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_LIGHT        = (T_LIGHT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WCNT_W           = 18;

  // Serial frame layout
  localparam int unsigned ADDR_BITS        = 8;
  localparam int unsigned FRAME_BITS       = 24;
  localparam int unsigned DATA_W           = 16;
  localparam int unsigned CODE_W           = 12;
  localparam int unsigned CODE_LSB         = 2;
  localparam int unsigned RW_BIT           = 7;

  // Register map
  localparam logic [7:0]  ADDR_CONFIG      = 8'h01;
  localparam logic [7:0]  ADDR_POWER_MODE  = 8'h37;
  localparam logic [7:0]  ADDR_PAT_UPPER   = 8'h3C;
  localparam logic [7:0]  ADDR_PAT_CODE    = 8'h3D;
  localparam logic [7:0]  ADDR_PAT_LOWER   = 8'h3E;
  localparam logic [15:0] CONFIG_RESET     = 16'h0002;
  localparam logic [15:0] ZERO_WORD        = 16'h0000;
  localparam int unsigned HP1_BIT          = 1;
  localparam int unsigned PAT_EN_BIT       = 15;

  // Power mode field, low two bits of the power-mode register
  typedef enum logic [1:0] {
    PM_SHUTDOWN = 2'h0,
    PM_STANDBY  = 2'h1,
    PM_DEEP     = 2'h2,
    PM_LIGHT    = 2'h3
  } asc_pmode_t;

  typedef enum logic [2:0] {
    PS_RUN   = 3'h1,
    PS_SLEEP = 3'h2,
    PS_WAKE  = 3'h4
  } asc_pstate_t;

  // Serial port pins after sampling
  typedef struct packed {
    logic sclk;
    logic sdenb_n;
    logic sdio;
  } asc_ser_t;

  // Register file
  typedef struct packed {
    logic [15:0] config_word;
    logic [15:0] power_mode;
    logic [15:0] pattern_control_upper;
    logic [15:0] pattern_code_word;
    logic [15:0] pattern_control_lower;
  } asc_regs_t;

  // Whole module state
  typedef struct packed {
    asc_ser_t              s1;
    asc_ser_t              s2;
    logic                  sclk_prev;
    logic [1:0]            en_sync;
    logic [7:0]            addr;
    logic [15:0]           shift;
    logic [4:0]            bit_cnt;
    asc_regs_t             regs;
    asc_pstate_t           pstate;
    logic [WCNT_W-1:0]     wcnt;
    logic                  phase;
    logic [CODE_W-1:0]     dout;
    logic                  dvalid;
    logic                  asleep;
    logic                  sdio_out;
    logic                  sdio_oe_n;
  } asc_state_t;
endpackage

// ==== logic/asc_ctrl.sv ====
// Sleep mode sequencing, serial register port and test-pattern output of a dual ADC
`timescale 1ns/100ps
module asc_ctrl #(
  parameter int unsigned SHUTDOWN_CYCLES = asc_pkg::CYC_SHUTDOWN,
  parameter int unsigned STANDBY_CYCLES  = asc_pkg::CYC_STANDBY
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  // Enable pin
  input  wire logic                       enable,
  // Serial configuration port
  input  wire logic                       sclk,
  input  wire logic                       sdenb_n,
  input  wire logic                       sdio_in,
  output logic                            sdio_out,
  output logic                            sdio_oe_n,
  // Conversion data in, sample data out
  input  wire logic [asc_pkg::CODE_W-1:0] adc_code,
  output logic      [asc_pkg::CODE_W-1:0] data_out,
  output logic                            data_valid,
  output logic                            asleep
);

  ////////////////////////////////////////////////////////////////////////////////
  asc_pkg::asc_state_t q;
  asc_pkg::asc_state_t d;

  // Code field of a pattern register
  function automatic logic [asc_pkg::CODE_W-1:0] code_field(input logic [15:0] w);
    return w[asc_pkg::CODE_LSB +: asc_pkg::CODE_W];
  endfunction

  // Wake-up delay of a power mode, in cycles minus one
  // Shutdown and standby are parameters so a bench can shorten the long waits
  function automatic logic [asc_pkg::WCNT_W-1:0] wake_cycles(input logic [1:0] m);
    logic [asc_pkg::WCNT_W-1:0] c;
    c = asc_pkg::WCNT_W'(asc_pkg::CYC_LIGHT);
    unique case (asc_pkg::asc_pmode_t'(m))
      asc_pkg::PM_SHUTDOWN: c = asc_pkg::WCNT_W'(SHUTDOWN_CYCLES);
      asc_pkg::PM_STANDBY:  c = asc_pkg::WCNT_W'(STANDBY_CYCLES);
      asc_pkg::PM_DEEP:     c = asc_pkg::WCNT_W'(asc_pkg::CYC_DEEP);
      asc_pkg::PM_LIGHT:    c = asc_pkg::WCNT_W'(asc_pkg::CYC_LIGHT);
    endcase
    return c - asc_pkg::WCNT_W'(1);
  endfunction

  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      reading;
  logic [7:0]                full_addr;
  logic [15:0]               full_data;
  logic [15:0]               rdata;
  logic                      pat_on;
  logic [asc_pkg::CODE_W-1:0] code_a;
  logic [asc_pkg::CODE_W-1:0] code_b;

  // Link clock edges are found on the synchronised copy, so each phase of
  // the link clock must last at least four clk_sys cycles
  assign sclk_rise = q.s2.sclk & ~q.sclk_prev;
  assign sclk_fall = ~q.s2.sclk & q.sclk_prev;
  assign reading   = q.addr[asc_pkg::RW_BIT];
  assign full_addr = {q.addr[6:0], q.s2.sdio};
  assign full_data = {q.shift[14:0], q.s2.sdio};
  assign code_a    = code_field(q.regs.pattern_code_word);
  assign code_b    = code_field(q.regs.pattern_control_lower);

  assign pat_on = ~q.regs.config_word[asc_pkg::HP1_BIT]
                & q.regs.pattern_control_upper[asc_pkg::PAT_EN_BIT];

  // Read-back mux; unmapped addresses read as zero
  // Bit 7 of the address word is the read flag, not part of the address
  always_comb begin
    unique case ({1'b0, full_addr[6:0]})
      asc_pkg::ADDR_CONFIG:     rdata = q.regs.config_word;
      asc_pkg::ADDR_POWER_MODE: rdata = q.regs.power_mode;
      asc_pkg::ADDR_PAT_UPPER:  rdata = q.regs.pattern_control_upper;
      asc_pkg::ADDR_PAT_CODE:   rdata = q.regs.pattern_code_word;
      asc_pkg::ADDR_PAT_LOWER:  rdata = q.regs.pattern_control_lower;
      default:                  rdata = asc_pkg::ZERO_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    // Pins pass two flops; only the second stage is looked at
    d.s1         = '{sclk: sclk, sdenb_n: sdenb_n, sdio: sdio_in};
    d.s2         = q.s1;
    d.sclk_prev  = q.s2.sclk;
    d.en_sync    = {q.en_sync[0], enable};

    // Serial frame: R/W and 7 address bits, then 16 data bits, MSB first
    if (q.s2.sdenb_n) begin
      // Frame ended or cut short: nothing commits and the line is released
      d.bit_cnt   = '0;
      d.sdio_oe_n = 1'b1;
    end else begin
      if (sclk_rise && q.bit_cnt < 5'(asc_pkg::FRAME_BITS)) begin
        d.bit_cnt = q.bit_cnt + 5'h01;
        if (q.bit_cnt < 5'(asc_pkg::ADDR_BITS)) begin
          d.addr = full_addr;
          if (q.bit_cnt == 5'(asc_pkg::ADDR_BITS - 1)) begin
            d.shift = rdata;
          end
        end else if (!reading) begin
          // Write frame: data shifts in, the register takes it at the last bit
          d.shift = full_data;
          if (q.bit_cnt == 5'(asc_pkg::FRAME_BITS - 1)) begin
            unique case ({1'b0, q.addr[6:0]})
              asc_pkg::ADDR_CONFIG:     d.regs.config_word           = full_data;
              asc_pkg::ADDR_POWER_MODE: d.regs.power_mode            = full_data;
              asc_pkg::ADDR_PAT_UPPER:  d.regs.pattern_control_upper = full_data;
              asc_pkg::ADDR_PAT_CODE:   d.regs.pattern_code_word     = full_data;
              asc_pkg::ADDR_PAT_LOWER:  d.regs.pattern_control_lower = full_data;
              default:                  d.regs = q.regs;
            endcase
          end
        end
      end
      // Read data leaves on falling edges so the host samples it on rising ones
      if (sclk_fall && reading && q.bit_cnt >= 5'(asc_pkg::ADDR_BITS)
          && q.bit_cnt < 5'(asc_pkg::FRAME_BITS)) begin
        d.sdio_out  = q.shift[15];
        d.shift     = {q.shift[14:0], 1'b0};
        d.sdio_oe_n = 1'b0;
      end
      if (q.bit_cnt == 5'(asc_pkg::FRAME_BITS) && sclk_fall) begin
        d.sdio_oe_n = 1'b1;
      end
    end

    // Sleep sequencing
    // Enable low during wake-up goes back to sleep and the count restarts,
    // so a short glitch on the pin cannot cut the settling time short
    unique case (q.pstate)
      asc_pkg::PS_RUN: begin
        if (!q.en_sync[1]) begin
          d.pstate = asc_pkg::PS_SLEEP;
        end
      end
      asc_pkg::PS_SLEEP: begin
        if (q.en_sync[1]) begin
          d.pstate = asc_pkg::PS_WAKE;
          d.wcnt   = wake_cycles(q.regs.power_mode[1:0]);
        end
      end
      asc_pkg::PS_WAKE: begin
        if (!q.en_sync[1]) begin
          d.pstate = asc_pkg::PS_SLEEP;
        end else if (q.wcnt == '0) begin
          d.pstate = asc_pkg::PS_RUN;
        end else begin
          d.wcnt = q.wcnt - asc_pkg::WCNT_W'(1);
        end
      end
    endcase
    d.asleep = (d.pstate == asc_pkg::PS_SLEEP);

    // valid only while running
    // Valid, asleep and data all follow the next state; from the present state
    // valid would overlap asleep for one cycle on entering sleep
    d.dvalid = (d.pstate == asc_pkg::PS_RUN);
    if (d.pstate != asc_pkg::PS_RUN) begin
      d.dout  = '0;
      d.phase = 1'b0;
    end else if (pat_on) begin
      d.phase = ~q.phase;
      // A zero second code holds the first one, giving the constant patterns
      if (code_b == '0 || !q.phase) begin
        d.dout = code_a;
      end else begin
        d.dout = code_b;
      end
    end else begin
      d.dout  = adc_code;
      d.phase = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      q                  <= '0;
      q.s1               <= '{sclk: 1'b0, sdenb_n: 1'b1, sdio: 1'b0};
      q.s2               <= '{sclk: 1'b0, sdenb_n: 1'b1, sdio: 1'b0};
      // Enable sync starts high: a part released with enable high runs at once
      q.en_sync          <= 2'h3;
      q.regs.config_word <= asc_pkg::CONFIG_RESET;
      q.pstate           <= asc_pkg::PS_RUN;
      q.sdio_oe_n        <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Every output is a state flop
  assign sdio_out   = q.sdio_out;
  assign sdio_oe_n  = q.sdio_oe_n;
  assign data_out   = q.dout;
  assign data_valid = q.dvalid;
  assign asleep     = q.asleep;

endmodule

// ==== sim/asc_ctrl_sva.sv ====
// Checker: sleep, wake and serial-port properties at the ports
`timescale 1ns/100ps
module asc_ctrl_sva #(
  parameter int unsigned SHUTDOWN_CYCLES = 40,
  parameter int unsigned STANDBY_CYCLES  = 20
) (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        enable,
  input wire logic        sdenb_n,
  input wire logic        sdio_oe_n,
  input wire logic [11:0] data_out,
  input wire logic        data_valid,
  input wire logic        asleep
);
  localparam int MINW = (STANDBY_CYCLES < 200) ? STANDBY_CYCLES : 200;
  logic [11:0] wcnt_q;
  // Cycles spent awake but not yet valid
  always_ff @(posedge clk_sys) begin
    if (!rstn || asleep || data_valid)
      wcnt_q <= 12'h000;
    else
      wcnt_q <= wcnt_q + 12'h001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_sleep_nodv; asleep |-> !data_valid; endproperty
  a_sleep_nodv: assert property (p_sleep_nodv) else $error("valid while asleep");
  property p_idle_zero; !data_valid |-> data_out == 12'h000; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("data while invalid");
  property p_en_sleep; !enable [*5] |=> asleep; endproperty
  a_en_sleep: assert property (p_en_sleep) else $error("no sleep on low enable");
  property p_en_wake; enable [*6] |=> !asleep; endproperty
  a_en_wake: assert property (p_en_wake) else $error("asleep with enable high");
  property p_wake_min; $rose(data_valid) |-> !$past(rstn, 2) || wcnt_q + 2 >= MINW; endproperty
  a_wake_min: assert property (p_wake_min) else $error("wake too short");
  property p_wake_max; wcnt_q < 12'h834; endproperty
  a_wake_max: assert property (p_wake_max) else $error("wake too long");
  property p_oe_idle; sdenb_n [*4] |-> sdio_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("drive outside frame");
  property p_oe_rel; $rose(sdenb_n) |-> ##[0:4] sdio_oe_n; endproperty
  a_oe_rel: assert property (p_oe_rel) else $error("drive not released");
endmodule

// ==== sim/asc_host.sv ====
// Serial configuration host model, link clock idle low between frames
`timescale 1ns/100ps
module asc_host (
  // Serial pins
  output logic      sclk,
  output logic      sdenb_n,
  output logic      sdio_h,
  input  wire logic sdio_w
);
  initial begin
    sclk = 1'b0;
    sdenb_n = 1'b1;
    sdio_h = 1'b0;
  end
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd,
                      output logic [15:0] rdat);
    logic [23:0] f;
    f = {rd, a, wd};
    rdat = 16'h0000;
    sdenb_n <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      // Released line toggles so a stale level never reads as data
      sdio_h <= (rd && i > 7) ? ~sdio_h : f[23-i];
      #62.5 sclk <= 1'b1;
      if (i > 7)
        rdat = {rdat[14:0], sdio_w};
      #62.5 sclk <= 1'b0;
    end
    #62.5 sdenb_n <= 1'b1;
    #200;
  endtask
endmodule

// ==== sim/asc_ctrl_tb.sv ====
// Testbench: register reads, test patterns, restore and sleep modes
`timescale 1ns/100ps
module asc_ctrl_tb;
  typedef struct {logic [15:0] c, w, l; logic [11:0] e0, e1;} asc_row_t;
  logic        clk_sys, rstn, enable, sclk, sdenb_n, sdio_h, sdio_out, sdio_oe_n;
  logic        data_valid, asleep;
  logic [11:0] adc_code, data_out, d0;
  logic [15:0] rd;
  int          err_total = 0, num_checks = 0, n;
  int          wk[4] = '{40, 20, 2000, 200};
  asc_row_t    rows[5] = '{'{16'h8000, 16'h0000, 16'h0000, 12'h000, 12'h000},
    '{16'hBFFC, 16'h3FFC, 16'h3FFC, 12'hFFF, 12'hFFF},
    '{16'h9554, 16'h2AA8, 16'h1554, 12'hAAA, 12'h555},
    '{16'hBFFC, 16'h0000, 16'h3FFC, 12'hFFF, 12'h000},
    '{16'h8000, 16'h2AF0, 16'h0000, 12'hABC, 12'hABC}};
  wire         sdio_w = sdio_oe_n ? sdio_h : sdio_out;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h exp %h", $time, a, b); end end
  asc_ctrl #(.SHUTDOWN_CYCLES(40), .STANDBY_CYCLES(20)) i_dut (.clk_sys(clk_sys),
    .rstn(rstn), .enable(enable), .sclk(sclk), .sdenb_n(sdenb_n), .sdio_in(sdio_w),
    .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .adc_code(adc_code),
    .data_out(data_out), .data_valid(data_valid), .asleep(asleep));
  asc_host i_host (.sclk(sclk), .sdenb_n(sdenb_n), .sdio_h(sdio_h), .sdio_w(sdio_w));
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_host.xfer(1'b0, a[6:0], d, rd);
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    i_host.xfer(1'b1, a[6:0], 16'h0000, rd);
    `CHK(rd, e)
  endtask
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #400us;
    err_total++;
    end_of_test();
  end
  initial begin
    rstn = 1'b0;
    enable = 1'b1;
    adc_code = 12'h000;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdchk(8'h01, 16'h0002);
    rdchk(8'h37, 16'h0000);
    rdchk(8'h7F, 16'h0000);
    $display("reset test done");
    wr(8'h01, 16'h0000);
    foreach (rows[k]) begin
      wr(8'h3C, rows[k].c);
      wr(8'h3D, rows[k].w);
      wr(8'h3E, rows[k].l);
      rdchk(8'h3D, rows[k].w);
      @(negedge clk_sys);
      d0 = data_out;
      @(negedge clk_sys);
      `CHK(d0 ^ data_out, rows[k].e0 ^ rows[k].e1)
      `CHK(d0 == rows[k].e0 || d0 == rows[k].e1, 1'b1)
      `CHK(data_valid, 1'b1)
      $display("pattern row %0d done", k);
    end
    @(posedge clk_sys);
    adc_code <= 12'h2C1;
    wr(8'h01, 16'h0002);
    @(negedge clk_sys);
    `CHK(data_out, 12'h2C1)
    for (int r = 0; r < 3; r++)
      wr(8'h3C + 8'(r), 16'h0000);
    adc_code <= 12'h5A3;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(data_out, 12'h5A3)
    $display("restore test done");
    foreach (wk[m]) begin
      wr(8'h37, 16'(m));
      enable <= 1'b0;
      repeat (10) @(posedge clk_sys);
      `CHK({asleep, data_valid, data_out}, 14'h2000)
      enable <= 1'b1;
      n = 0;
      while (data_valid !== 1'b1 && n < 3000) begin
        @(posedge clk_sys);
        n++;
      end
      `CHK(n >= wk[m] && n <= wk[m] + 10, 1'b1)
      $display("sleep mode %0d done", m);
    end
    // Enable dropped during wake-up: back to sleep, next wake counts in full
    enable <= 1'b0;
    repeat (10) @(posedge clk_sys);
    enable <= 1'b1;
    repeat (10) @(posedge clk_sys);
    enable <= 1'b0;
    repeat (10) @(posedge clk_sys);
    `CHK({asleep, data_valid}, 2'h2)
    enable <= 1'b1;
    n = 0;
    while (data_valid !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(n >= wk[3] && n <= wk[3] + 10, 1'b1)
    $display("interrupted wake done");
    // Reset in mid-run: outputs and registers return to their reset values
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    `CHK({asleep, data_valid, data_out, sdio_oe_n}, 15'h0001)
    @(negedge clk_sys);
    `CHK(data_valid, 1'b1)
    rdchk(8'h37, 16'h0000);
    rdchk(8'h01, 16'h0002);
    $display("mid-run reset done");
    end_of_test();
  end
endmodule
bind asc_ctrl asc_ctrl_sva #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES),
  .STANDBY_CYCLES(STANDBY_CYCLES)) i_sva (.clk_sys(clk_sys), .rstn(rstn),
  .enable(enable), .sdenb_n(sdenb_n), .sdio_oe_n(sdio_oe_n), .data_out(data_out),
  .data_valid(data_valid), .asleep(asleep));
